// file: logic/sid_lookup_pkg.sv
// constants shared by the compressed stream-id lookup block
package sid_lookup_pkg;
  localparam int          SID_W        = 16;               // stream identifier width
  localparam int          WORD_CNT     = 16384;            // table words, 65536 ids / 4
  localparam int          WIDX_W       = 14;               // word index width
  localparam int          FIELD_W      = 8;                // selector field width
  localparam int          SEL_W        = 7;                // usable selector bits, bit 7 reserved
  localparam int          NUM_S2CR     = 64;               // stream-to-context registers built
  localparam int          ADDR_W       = 20;               // byte address width of the slave
  localparam int          PAGE_SPAN    = 4096;             // page span in bytes
  localparam logic [19:0] TABLE_BASE   = 20'h08000;        // 8 * page span
  localparam logic [19:0] TABLE_END    = 20'h18000;        // base + 65536 bytes
  localparam logic [19:0] CTRL_OFS     = 20'h00000;        // control register
  localparam logic [19:0] ID_OFS       = 20'h00004;        // identification register
  localparam int          OWN_BIT      = 0;                // secure owns the lookup
  localparam int          EN_NS_BIT    = 1;                // non-secure enable
  localparam int          EN_S_BIT     = 2;                // secure enable
  localparam int          GSO_BIT      = 3;                // global space secure only
  localparam int          SUP_BIT      = 0;                // capability flag position
  localparam logic [6:0]  NS_FIRST     = 7'h20;            // first register owned by non-secure
  localparam logic [1:0]  RESP_OKAY    = 2'h0;             // axi okay
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;             // axi slave error
  localparam logic        IMPLEMENTED  = 1'b1;             // extension built in
endpackage

// file: logic/stream_id_compressed_lookup.sv
// compressed stream-id lookup table with axi4-lite register slave
// Functional notes
// - capability flag reads one to secure reads
// - full sixteen-bit stream ids index the table
// - only one security state uses lookup
// - ownership bit resets zero, one means secure
// - non-secure flag set only when owned there
// - non-owning state uses ordinary stream matching
// - lookup active only after owner enable set
// - words hold four byte selector fields
// - word id/4, field id mod 4
// - field gives stream-to-context register number
// - bad or foreign selector means unmatched
// - disabled table reads unknown, ignores writes
// - original stream id stays the identity
// - match registers unused by lookup state
// - word n at eight pages plus 4n
// - byte and word accesses are atomic
// - secure-owned table is zero/ignored to non-secure
// - secure-only space hides table from non-secure
// - selector bit seven and unused bits zero
module stream_id_compressed_lookup (
  input  wire logic        clock,
  input  wire logic        resetn,
  // axi4-lite slave, awprot[1]/arprot[1] high means non-secure
  input  wire logic [19:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [19:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // transaction side
  input  wire logic        txnValid,
  input  wire logic [15:0] txnStreamId,
  input  wire logic        txnSecure,
  output logic             lookupValid,
  output logic             lookupMatched,
  output logic [6:0]       lookupIndex,
  output logic [15:0]      lookupStreamId,
  output logic             lookupSecure,
  output logic             useStreamMatch
);

  // no reset on the table: software fills what it uses
  // after enabling; a real build maps this onto a ram
  logic [31:0] table_r [0:16383];       // the lookup words, no reset: contents unknown
  logic        ownSecure_r;             // secure owns the lookup
  logic        enNs_r;                  // non-secure enable
  logic        enS_r;                   // secure enable
  logic        secureOnly_r;            // global space secure only
  logic        awHeld_r;                // write address captured
  logic [19:0] awAddr_r;                // captured write address
  logic        awNs_r;                  // captured write non-secure
  logic        wHeld_r;                 // write data captured
  logic [31:0] wData_r;                 // captured write data
  logic [3:0]  wStrb_r;                 // captured strobes

  // word index of a byte address inside the table window
  function automatic logic [13:0] word_of(input logic [19:0] a);
    logic [19:0] d;
    d = a - sid_lookup_pkg::TABLE_BASE;
    return d[15:2];
  endfunction

  // address falls inside the table window
  function automatic logic in_table(input logic [19:0] a);
    return (a >= sid_lookup_pkg::TABLE_BASE) && (a < sid_lookup_pkg::TABLE_END);
  endfunction

  // table reachable: owning state enabled, non-secure filtered
  // non-secure sees the table only while it owns it,
  // the global space is open and its enable is set;
  // secure follows the enable of the owning state,
  // so a disabled table ignores writes from both sides
  function automatic logic table_open(input logic ns, input logic own, input logic ens,
                                      input logic es, input logic gso);
    logic ok;
    if (ns) begin
      ok = !own && !gso && ens;
    end else begin
      ok = own ? es : ens;
    end
    return ok;
  endfunction

  // clear reserved selector bits in every field
  function automatic logic [31:0] mask_fields(input logic [31:0] v);
    logic [31:0] m;
    m = v;
    for (int k = 0; k < 4; k++) begin
      m[k*8+7] = 1'b0;
    end
    return m;
  endfunction

  logic wrFire;                         // both halves of a write present
  logic [19:0] wrAddr;                  // effective write address
  logic        wrNs;                    // effective write non-secure
  logic [31:0] wrData;                  // effective write data
  logic [3:0]  wrStrb;                  // effective strobes
  logic        wrOk;                    // table write permitted
  logic        wrCtrl;                  // control register write

  // join captured and live halves so either order works
  // an early half is parked in the _r copies and the
  // live channel gives the other, so any order fires once;
  // bvalid holds off a second write until its answer
  always_comb begin
    wrAddr = awHeld_r ? awAddr_r : awaddr;
    wrNs   = awHeld_r ? awNs_r : awprot[1];
    wrData = wHeld_r ? wData_r : wdata;
    wrStrb = wHeld_r ? wStrb_r : wstrb;
    wrFire = (awHeld_r || (awvalid && awready)) && (wHeld_r || (wvalid && wready)) && !bvalid;
    wrOk   = wrFire && in_table(wrAddr) && table_open(wrNs, ownSecure_r, enNs_r, enS_r, secureOnly_r);
    wrCtrl = wrFire && (wrAddr == sid_lookup_pkg::CTRL_OFS) && !wrNs;
  end

  // write address channel
  // ready is a one-cycle pulse that stays low while an
  // address is parked or a response is pending
  always_ff @(posedge clock) begin
    if (!resetn) begin
      awready  <= 1'b0;
      awHeld_r <= 1'b0;
      awAddr_r <= 20'h00000;
      awNs_r   <= 1'b0;
    end else begin
      awready <= !awHeld_r && !awready && !bvalid && !wrFire;
      if (wrFire) begin
        awHeld_r <= 1'b0;
      end else if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
        awNs_r   <= awprot[1];
      end
    end
  end

  // write data channel
  // same pulse scheme as the address channel, so both
  // halves are usually taken on the same edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wready  <= 1'b0;
      wHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else begin
      wready <= !wHeld_r && !wready && !bvalid && !wrFire;
      if (wrFire) begin
        wHeld_r <= 1'b0;
      end else if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
    end
  end

  // write response; unmapped addresses answer slave error
  // filtered or disabled accesses still answer okay;
  // only addresses outside every register are refused
  always_ff @(posedge clock) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp  <= sid_lookup_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp  <= (in_table(wrAddr) || wrAddr == sid_lookup_pkg::CTRL_OFS || wrAddr == sid_lookup_pkg::ID_OFS)
                ? sid_lookup_pkg::RESP_OKAY : sid_lookup_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // table write, one strobe per byte lane so byte writes are atomic
  // no reset branch: the array keeps whatever it held,
  // and a refused write leaves the word untouched;
  // half-word strobes also land, lane by lane
  always_ff @(posedge clock) begin
    if (wrOk) begin
      for (int k = 0; k < 4; k++) begin
        if (wrStrb[k]) begin
          table_r[word_of(wrAddr)][k*8 +: 8] <= wrData[k*8 +: 8];
        end
      end
    end
  end

  // control register, secure writes only; non-secure writes ignored
  // bit 0 hands the lookup to secure, bit 1 and bit 2
  // enable it for non-secure and secure, bit 3 closes
  // the global space to non-secure; only byte lane 0
  // matters, so a byte write to offset zero is enough
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ownSecure_r  <= 1'b0;
      enNs_r       <= 1'b0;
      enS_r        <= 1'b0;
      secureOnly_r <= 1'b0;
    end else if (wrCtrl && wrStrb[0]) begin
      ownSecure_r  <= wrData[sid_lookup_pkg::OWN_BIT];
      enNs_r       <= wrData[sid_lookup_pkg::EN_NS_BIT];
      enS_r        <= wrData[sid_lookup_pkg::EN_S_BIT];
      secureOnly_r <= wrData[sid_lookup_pkg::GSO_BIT];
    end
  end

  // read channel: one read at a time, answer one cycle after acceptance
  // ready pulses while idle; the answer stands until
  // rready. limitation: a disabled table returns the
  // stored bits rather than a fresh unknown, which
  // software must not rely on
  always_ff @(posedge clock) begin
    if (!resetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= sid_lookup_pkg::RESP_OKAY;
    end else begin
      arready <= !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= sid_lookup_pkg::RESP_OKAY;
        rdata  <= 32'h00000000;
        if (in_table(araddr)) begin
          // disabled table returns stale contents, which counts as unknown
          if (arprot[1] && (ownSecure_r || secureOnly_r)) begin
            rdata <= 32'h00000000;
          end else begin
            rdata <= mask_fields(table_r[word_of(araddr)]);
          end
        end else if (araddr == sid_lookup_pkg::ID_OFS) begin
          rdata[sid_lookup_pkg::SUP_BIT] <= arprot[1] ? (sid_lookup_pkg::IMPLEMENTED && !ownSecure_r)
                                                      : sid_lookup_pkg::IMPLEMENTED;
        end else if (araddr == sid_lookup_pkg::CTRL_OFS) begin
          if (!arprot[1]) begin
            rdata[3:0] <= {secureOnly_r, enS_r, enNs_r, ownSecure_r};
          end
        end else begin
          rresp <= sid_lookup_pkg::RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // decode of the incoming transaction, valid only
  // in the cycle in which txnValid is high
  logic        txnOwner;                // transaction state owns the lookup
  logic [31:0] txnWord;                 // fetched table word
  logic [7:0]  txnField;                // selected field
  logic        txnGood;                 // field names a usable register

  // fetch and check the selector for an incoming transaction
  // the array read is combinational so the answer is
  // one cycle after the transaction; trade-off: a wide
  // read mux instead of a pipelined ram port
  // the non-owning or disabled state goes to matching
  always_comb begin
    txnOwner = (txnSecure == ownSecure_r) && (txnSecure ? enS_r : enNs_r);
    txnWord  = table_r[txnStreamId[15:2]];
    txnField = txnWord[txnStreamId[1:0]*8 +: 8];
    // low registers are secure, upper ones non-secure; out of range is unmatched
    txnGood  = !txnField[7] && (txnField < sid_lookup_pkg::NUM_S2CR) &&
               (txnSecure ? (txnField[6:0] < sid_lookup_pkg::NS_FIRST)
                          : (txnField[6:0] >= sid_lookup_pkg::NS_FIRST));
  end

  // lookup result toward the context-selection stage
  // outputs stand for one cycle per transaction; the
  // stream id is copied through so the identity stays
  // the original id, never the selector value
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lookupValid    <= 1'b0;
      lookupMatched  <= 1'b0;
      lookupIndex    <= 7'h00;
      lookupStreamId <= 16'h0000;
      lookupSecure   <= 1'b0;
      useStreamMatch <= 1'b0;
    end else begin
      lookupValid    <= txnValid && txnOwner;
      lookupMatched  <= txnValid && txnOwner && txnGood;
      lookupIndex    <= txnGood ? txnField[6:0] : 7'h00;
      lookupStreamId <= txnStreamId;
      lookupSecure   <= txnSecure;
      useStreamMatch <= txnValid && !txnOwner;
    end
  end

  // helper for the ignore check: snapshot of the word
  // that a refused table write aimed at
  logic        wrRefused_r;             // last edge held a refused table write
  logic [13:0] refIdx_r;                // word that write aimed at
  logic [31:0] refWord_r;               // that word before the write

  // capture every refused table write
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrRefused_r <= 1'b0;
      refIdx_r    <= 14'h0000;
      refWord_r   <= 32'h00000000;
    end else begin
      wrRefused_r <= wrFire && in_table(wrAddr) && !wrOk;
      refIdx_r    <= word_of(wrAddr);
      refWord_r   <= table_r[word_of(wrAddr)];
    end
  end

  // checks on the register bus and the lookup path
  ns_flag_a: assert property (@(posedge clock) disable iff (!resetn)
    (arvalid && arready && arprot[1] && araddr == sid_lookup_pkg::ID_OFS) |=> (rdata[0] == !$past(ownSecure_r)))
    else $error("non-secure capability flag wrong");
  sec_flag_a: assert property (@(posedge clock) disable iff (!resetn)
    (arvalid && arready && !arprot[1] && araddr == sid_lookup_pkg::ID_OFS) |=> rdata[0])
    else $error("secure capability flag not set");
  ns_hidden_a: assert property (@(posedge clock) disable iff (!resetn)
    (arvalid && arready && arprot[1] && in_table(araddr) && (ownSecure_r || secureOnly_r)) |=> (rdata == 32'h00000000))
    else $error("table visible to non-secure");
  res_bit_a: assert property (@(posedge clock) disable iff (!resetn)
    (rvalid && rresp == sid_lookup_pkg::RESP_OKAY) |-> !(rdata[7] | rdata[15] | rdata[23] | rdata[31]))
    else $error("reserved selector bit read set");
  one_state_a: assert property (@(posedge clock) disable iff (!resetn)
    lookupValid |-> (lookupSecure == ownSecure_r || $changed(ownSecure_r)))
    else $error("lookup served wrong state");
  own_reset_a: assert property (@(posedge clock) $rose(resetn) |-> !ownSecure_r)
    else $error("ownership not zero after reset");
  exclusive_a: assert property (@(posedge clock) disable iff (!resetn)
    ($past(txnValid) == (lookupValid || useStreamMatch)) && !(lookupValid && useStreamMatch))
    else $error("lookup and stream match together");
  id_keep_a: assert property (@(posedge clock) disable iff (!resetn)
    $past(txnValid) |-> (lookupStreamId == $past(txnStreamId)))
    else $error("stream identity replaced");
  enable_gate_a: assert property (@(posedge clock) disable iff (!resetn)
    (txnValid && !txnSecure && !enNs_r) |=> !lookupValid)
    else $error("lookup active while disabled");
  bad_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    (txnValid && txnOwner && txnField[7]) |=> (lookupValid && !lookupMatched))
    else $error("bad selector matched");
  // the forwarded number is the selected field itself
  fwd_index_a: assert property (@(posedge clock) disable iff (!resetn)
    (txnValid && txnOwner && txnGood) |=> (lookupMatched && lookupIndex == $past(txnField[6:0])))
    else $error("forwarded register number wrong");
  // a matched lookup names a register of its own half
  sel_range_a: assert property (@(posedge clock) disable iff (!resetn)
    lookupMatched |-> ((lookupIndex < sid_lookup_pkg::NUM_S2CR) &&
      (lookupSecure == (lookupIndex < sid_lookup_pkg::NS_FIRST))))
    else $error("matched selector out of range");
  // non-secure writes never move the ownership bit
  own_guard_a: assert property (@(posedge clock) disable iff (!resetn)
    (wrFire && wrNs) |=> $stable(ownSecure_r))
    else $error("non-secure write moved ownership");
  // a refused table write leaves the word as it was
  wr_ignored_a: assert property (@(posedge clock) disable iff (!resetn)
    wrRefused_r |-> (table_r[refIdx_r] == refWord_r))
    else $error("refused table write changed a word");

  wr_cov_c: cover property (@(posedge clock) disable iff (!resetn) wrOk);
  look_cov_c: cover property (@(posedge clock) disable iff (!resetn) lookupMatched);
  sm_cov_c: cover property (@(posedge clock) disable iff (!resetn) useStreamMatch);
  hide_cov_c: cover property (@(posedge clock) disable iff (!resetn) arvalid && arready && arprot[1] && ownSecure_r);
  sec_look_c: cover property (@(posedge clock) disable iff (!resetn) lookupValid && lookupSecure);

endmodule

// file: verif/txn_source.sv
// model of the client masters that issue stream-id tagged transactions
module txn_source (
  input  wire logic        clock,
  output logic             txnValid,
  output logic [15:0]      txnStreamId,
  output logic             txnSecure
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle lines at time zero
  initial begin
    txnValid    = 1'b0;
    txnStreamId = 16'h0000;
    txnSecure   = 1'b0;
  end
  // one transaction per call, calls in a row give one per cycle
  task automatic send(input logic [15:0] id, input logic sec);
    @(posedge clock);
    txnValid    <= 1'b1;
    txnStreamId <= id;
    txnSecure   <= sec;
  endtask
  // release; qualifiers are inverted so a late sample cannot pass for the last transaction
  task automatic idle();
    @(posedge clock);
    txnValid    <= 1'b0;
    txnStreamId <= ~txnStreamId;
    txnSecure   <= ~txnSecure;
  endtask
endmodule

// file: verif/stream_id_compressed_lookup_tb.sv
// self-checking bench for the compressed stream-id lookup block
module stream_id_compressed_lookup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rd_exp_t;  // read note
  typedef struct packed {logic [26:0] v; logic [26:0] m;} lk_exp_t;                  // lookup note
  logic        clock, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, txnValid, txnSecure;
  logic        lookupValid, lookupMatched, lookupSecure, useStreamMatch;
  logic [19:0] awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] txnStreamId, lookupStreamId;
  logic [6:0]  lookupIndex;
  int          miscompares, n_checks, words[$];
  rd_exp_t     rdQ[$];
  logic [1:0]  bQ[$];           // expected write answers
  lk_exp_t     lkQ[$];
  logic [31:0] shadow[int];     // bench copy of the table
  logic        ownSec, enOn;    // bench view of owner and enable
  stream_id_compressed_lookup dut (.clock(clock), .resetn(resetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .txnValid(txnValid),
    .txnStreamId(txnStreamId), .txnSecure(txnSecure), .lookupValid(lookupValid), .lookupMatched(lookupMatched),
    .lookupIndex(lookupIndex), .lookupStreamId(lookupStreamId), .lookupSecure(lookupSecure),
    .useStreamMatch(useStreamMatch));
  txn_source pm (.clock(clock), .txnValid(txnValid), .txnStreamId(txnStreamId), .txnSecure(txnSecure));
  // free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic fail(input string msg);
    miscompares++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one write; each channel is released at its own handshake
  task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s, input logic ns,
                    input logic [1:0] r = sid_lookup_pkg::RESP_OKAY);
    int i;
    bQ.push_back(r);
    @(posedge clock);
    awaddr  <= a;
    awprot  <= {1'b0, ns, 1'b0};
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 64) begin
      fail("write timeout");
      print_verdict();
    end
  endtask
  // one read; the expected answer is noted before the request goes out
  task automatic rd(input logic [19:0] a, input logic ns, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    int i;
    rdQ.push_back('{d, m, r});
    @(posedge clock);
    araddr  <= a;
    arprot  <= {1'b0, ns, 1'b0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 64) begin
      fail("read timeout");
      print_verdict();
    end
  endtask
  function automatic logic [19:0] taddr(input int n);
    return sid_lookup_pkg::TABLE_BASE + 20'(n * 4);
  endfunction
  // selector kinds: non-secure half, secure half, reserved bit set, past the last register
  function automatic logic [7:0] pick(input int k);
    logic [7:0] r;
    r = 8'($urandom);
    case (k)
      0: return 8'h20 | (r & 8'h1f);
      1: return r & 8'h1f;
      2: return 8'h80 | (r & 8'h1f);
      default: return 8'h40 | (r & 8'h3f);
    endcase
  endfunction
  task automatic fill(input int n, input int kinds, input logic ns);
    logic [31:0] d;
    for (int f = 0; f < 4; f++) d[f*8 +: 8] = pick($urandom % kinds);
    wr(taddr(n), d, 4'hf, ns);
    shadow[n] = d;
  endtask
  // reserved bit 7 of every field reads zero
  task automatic chkword(input int n, input logic ns);
    rd(taddr(n), ns, shadow[n] & 32'h7f7f7f7f, 32'hffffffff, sid_lookup_pkg::RESP_OKAY);
  endtask
  // note the expected lookup answer and issue the transaction
  task automatic look(input logic [15:0] id, input logic sec);
    logic [31:0] w;
    logic [7:0]  f;
    logic        good;
    w = shadow.exists(int'(id[15:2])) ? shadow[int'(id[15:2])] : 32'h80808080;
    f = w[8*id[1:0] +: 8];
    good = !f[7] && int'(f[6:0]) < sid_lookup_pkg::NUM_S2CR && ((f[6:0] >= sid_lookup_pkg::NS_FIRST) != sec);
    if (sec == ownSec && enOn) lkQ.push_back('{{2'b10, good, good ? f[6:0] : 7'h00, id, sec}, {27{1'b1}}});
    else lkQ.push_back('{{2'b01, 25'h0}, {2'b11, 25'h0}});
    pm.send(id, sec);
  endtask
  task automatic cmp_rd(input logic [33:0] got);
    rd_exp_t e;
    n_checks++;
    if (rdQ.size() == 0) begin
      fail("unexpected read answer");
      return;
    end
    e = rdQ.pop_front();
    if ({got[33:2] & e.m, got[1:0]} !== {e.d & e.m, e.r}) fail("read answer mismatch");
  endtask
  task automatic cmp_lk(input logic [26:0] got);
    lk_exp_t e;
    n_checks++;
    if (lkQ.size() == 0) begin
      fail("unexpected lookup answer");
      return;
    end
    e = lkQ.pop_front();
    if ((got & e.m) !== (e.v & e.m)) fail("lookup answer mismatch");
  endtask
  task automatic cmp_wr(input logic [1:0] got);
    n_checks++;
    if (bQ.size() == 0) begin
      fail("unexpected write answer");
      return;
    end
    if (got !== bQ.pop_front()) fail("write answer mismatch");
  endtask
  // watcher: takes the oldest note whenever an answer shows
  always @(posedge clock) begin
    if (rvalid === 1'b1 && rready === 1'b1) cmp_rd({rdata, rresp});
    if (bvalid === 1'b1 && bready === 1'b1) cmp_wr(bresp);
    if (lookupValid === 1'b1 || useStreamMatch === 1'b1)
      cmp_lk({lookupValid, useStreamMatch, lookupMatched, lookupIndex, lookupStreamId, lookupSecure});
  end
  // main sequence
  initial begin
    {resetn, awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready, araddr, arprot, arvalid, rready} = '0;
    {ownSec, enOn} = 2'b00;
    void'($urandom(32'hdd198184));
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd(sid_lookup_pkg::ID_OFS, 1'b0, 32'h1, 32'h1, sid_lookup_pkg::RESP_OKAY);
    rd(sid_lookup_pkg::ID_OFS, 1'b1, 32'h1, 32'h1, sid_lookup_pkg::RESP_OKAY);
    rd(sid_lookup_pkg::CTRL_OFS, 1'b0, 32'h0, 32'hf, sid_lookup_pkg::RESP_OKAY);
    look(16'h0001, 1'b0);
    pm.idle();
    $display("done: reset state");
    // disabled table ignores writes
    wr(sid_lookup_pkg::CTRL_OFS, 32'h2, 4'hf, 1'b0);
    enOn = 1'b1;
    fill(5, 4, 1'b1);
    wr(sid_lookup_pkg::CTRL_OFS, 32'h0, 4'hf, 1'b0);
    wr(taddr(5), ~shadow[5], 4'hf, 1'b1);
    wr(sid_lookup_pkg::CTRL_OFS, 32'h2, 4'hf, 1'b0);
    chkword(5, 1'b1);
    $display("done: disabled writes");
    // table filled before use, end words included
    words = {0, 16383};
    repeat (4) words.push_back($urandom % sid_lookup_pkg::WORD_CNT);
    foreach (words[k]) fill(words[k], 4, 1'b1);
    foreach (words[k]) chkword(words[k], 1'b1);
    wr(taddr(words[2]), 32'hff2affff, 4'b0100, 1'b1);
    shadow[words[2]][23:16] = 8'h2a;
    chkword(words[2], 1'b1);
    foreach (words[k]) for (int m = 0; m < 4; m++) look(16'(words[k] * 4 + m), 1'b0);
    look(16'hffff, 1'b1);
    look(16'hfffe, 1'b0);
    pm.idle();
    $display("done: non-secure lookups");
    // secure state takes the lookup
    wr(sid_lookup_pkg::CTRL_OFS, 32'h5, 4'hf, 1'b0);
    ownSec = 1'b1;
    rd(sid_lookup_pkg::ID_OFS, 1'b1, 32'h0, 32'h1, sid_lookup_pkg::RESP_OKAY);
    fill(words[0], 2, 1'b0);
    wr(taddr(words[0]), 32'h21212121, 4'hf, 1'b1);
    rd(taddr(words[0]), 1'b1, 32'h0, 32'hffffffff, sid_lookup_pkg::RESP_OKAY);
    chkword(words[0], 1'b0);
    for (int m = 0; m < 4; m++) look(16'(m), 1'b1);
    look(16'h0002, 1'b0);
    pm.idle();
    $display("done: secure owner");
    // global secure-only hides the table from non-secure
    wr(sid_lookup_pkg::CTRL_OFS, 32'ha, 4'hf, 1'b0);
    ownSec = 1'b0;
    wr(sid_lookup_pkg::CTRL_OFS, 32'h5, 4'hf, 1'b1);
    rd(sid_lookup_pkg::CTRL_OFS, 1'b0, 32'ha, 32'hf, sid_lookup_pkg::RESP_OKAY);
    rd(taddr(words[1]), 1'b1, 32'h0, 32'hffffffff, sid_lookup_pkg::RESP_OKAY);
    wr(taddr(words[1]), 32'h21212121, 4'hf, 1'b1);
    wr(sid_lookup_pkg::CTRL_OFS, 32'h2, 4'hf, 1'b0);
    chkword(words[1], 1'b1);
    rd(20'h20000, 1'b0, 32'h0, 32'hffffffff, sid_lookup_pkg::RESP_SLVERR);
    wr(20'h20000, 32'h0, 4'hf, 1'b0, sid_lookup_pkg::RESP_SLVERR);
    $display("done: filters and unmapped");
    repeat (4) @(posedge clock);
    if (rdQ.size() != 0 || lkQ.size() != 0 || bQ.size() != 0) fail("answers missing");
    print_verdict();
  end
endmodule
